// *** fan_params.svh ***
// named offsets, field positions, reset values and mode codes
// assumes inclusion by bare name from the package and the design
`ifndef FAN_PARAMS_SVH
`define FAN_PARAMS_SVH
// register offsets on the plain register port
`define FAN_OFS_ABILITY     5'h05
`define FAN_OFS_EXPANSION   5'h06
`define FAN_OFS_NP_TX       5'h07
`define FAN_OFS_LP_NP       5'h08
// expansion register field positions
`define FAN_EXP_LP_NP_ABLE  3
`define FAN_EXP_LOCAL_NP    2
`define FAN_EXP_PAGE_RCVD   1
`define FAN_EXP_LP_AN_ABLE  0
// code word field positions
`define FAN_CW_NP           15
`define FAN_CW_ACK          14
`define FAN_CW_MP           13
`define FAN_CW_ACK2         12
`define FAN_CW_TOGGLE       11
`define FAN_CW_MSG_HI       10
// reset values
`define FAN_RST_MSG         11'h001
`define FAN_RST_MP          1'h1
`define FAN_RST_WORD        16'h0000
// serial interface personality codes
`define FAN_MODE_FX         2'h0
`define FAN_MODE_1000X      2'h1
`define FAN_MODE_SGMII_SYS  2'h2
`define FAN_MODE_SGMII_MED  2'h3
// sgmii media: low seven received base-page bits
`define FAN_SGMII_LOW_HI    6
`define FAN_SGMII_LOW_PAT   7'h01
// matching config code groups needed for partner ability
`define FAN_MATCH_NEED      3
`endif

// *** fan_pkg.sv ***
// types shared by the page-exchange block
// assumes fan_params.svh on the include path
package fan_pkg;
   `include "fan_params.svh"

   // interface personality
   typedef enum logic [1:0] {
      FAN_FX        = `FAN_MODE_FX,
      FAN_1000X     = `FAN_MODE_1000X,
      FAN_SGMII_SYS = `FAN_MODE_SGMII_SYS,
      FAN_SGMII_MED = `FAN_MODE_SGMII_MED
   } fan_mode_t;

   // one received page from the receive state machine
   typedef struct packed {
      logic        valid;   // one-cycle pulse
      logic        is_next; // next page, else base page
      logic [15:0] word;    // received code word
   } fan_rx_page_t;

   // all state of the block
   typedef struct packed {
      logic [15:0] ability;
      logic        lp_np_able;
      logic        page_rcvd;
      logic        lp_an_able;
      logic        tx_np;
      logic        tx_mp;
      logic        tx_ack2;
      logic        tx_toggle;
      logic [10:0] tx_msg;
      logic        np_loaded;
      logic [15:0] lp_np;
      logic [3:0]  match_cnt;
      logic [15:0] last_cfg;
      logic [15:0] rd_data;
      logic [15:0] tx_word;
   } fan_state_t;
endpackage

// *** fan_page_xchg.sv ***
// page-exchange and expansion status registers of the fiber link
// assumes pcs/receive logic on clk_i delivers pages and config groups
`timescale 1ns/1ps
// offsets and field positions; the guard makes a second include harmless
`include "fan_params.svh"

module fan_page_xchg
   import fan_pkg::*;
#(
   parameter int MATCH_NEED = `FAN_MATCH_NEED
) (
   input  wire logic         clk_i,
   input  wire logic         rstn_i,
   input  wire logic         sw_reset_i,
   input  wire logic [1:0]   mode_i,
   input  wire logic         an_enable_i,
   input  wire logic         link_up_i,
   input  wire logic         sync_ok_i,
   input  wire fan_rx_page_t rx_page_i,
   input  wire logic         cfg_valid_i,
   input  wire logic [15:0]  cfg_word_i,
   input  wire logic         np_consumed_i,
   input  wire logic [4:0]   reg_addr_i,
   input  wire logic [15:0]  reg_wdata_i,
   input  wire logic         reg_wr_i,
   input  wire logic         reg_rd_i,
   output logic [15:0]       reg_rdata_o,
   output logic [15:0]       tx_word_o,
   output logic              np_loaded_o,
   output logic              lp_an_able_o
);

   // counter holds at most 15 matches; refuse others at elaboration
   if (MATCH_NEED < 1 || MATCH_NEED > 15) begin
      $error("MATCH_NEED must lie in 1..15");
   end

   localparam logic [3:0] MATCH_N = 4'(MATCH_NEED); // sized for counter

   fan_state_t st;       // registered state
   fan_state_t next_st;  // next state
   fan_mode_t  mode;     // decoded personality

   logic is_1000x;       // 1000base-x personality
   logic is_sgmii_med;   // sgmii media personality
   logic base_pg;        // base page taken this cycle
   logic next_pg;        // next page taken this cycle
   logic wr_np;          // write to transmit register
   logic rd_exp;         // read of expansion register
   logic [15:0] exp_val; // expansion register view
   logic [15:0] np_val;  // transmit register view

   // personality decode; mode comes from same-clock config logic
   assign mode         = fan_mode_t'(mode_i);
   assign is_1000x     = (mode == FAN_1000X);
   assign is_sgmii_med = (mode == FAN_SGMII_MED);

   // page events only count while the link stands
   assign base_pg = rx_page_i.valid & ~rx_page_i.is_next & link_up_i;
   assign next_pg = rx_page_i.valid & rx_page_i.is_next & link_up_i;
   assign wr_np   = reg_wr_i & (reg_addr_i == `FAN_OFS_NP_TX);
   assign rd_exp  = reg_rd_i & (reg_addr_i == `FAN_OFS_EXPANSION);

   // expansion view; reserved upper bits tie to zero
   always_comb begin
      exp_val = 16'h0000;
      exp_val[`FAN_EXP_LP_NP_ABLE] = st.lp_np_able & is_1000x;
      exp_val[`FAN_EXP_LOCAL_NP]   = 1'b1;
      exp_val[`FAN_EXP_PAGE_RCVD]  = st.page_rcvd;
      exp_val[`FAN_EXP_LP_AN_ABLE] = st.lp_an_able;
   end

   // transmit register as code word; bit 14 stays zero
   always_comb begin
      np_val = 16'h0000;
      np_val[`FAN_CW_NP]     = st.tx_np;
      np_val[`FAN_CW_MP]     = st.tx_mp;
      np_val[`FAN_CW_ACK2]   = st.tx_ack2;
      np_val[`FAN_CW_TOGGLE] = st.tx_toggle;
      np_val[`FAN_CW_MSG_HI:0] = st.tx_msg;
   end

   // next-state logic for every field
   always_comb begin
      next_st = st;

      // sgmii media partner ability: reload per base page
      if (!link_up_i) begin
         next_st.ability = `FAN_RST_WORD;
      end else if (base_pg && is_sgmii_med) begin
         next_st.ability = rx_page_i.word;
      end

      // partner next-page able flag
      if (!link_up_i) begin
         next_st.lp_np_able = 1'b0;
      end else if (base_pg && is_1000x
                   && rx_page_i.word[`FAN_CW_NP]) begin
         next_st.lp_np_able = 1'b1;
      end

      // page received: read clears, a new page wins over the read
      if (rx_page_i.valid && link_up_i) begin
         next_st.page_rcvd = 1'b1;
      end else if (rd_exp) begin
         next_st.page_rcvd = 1'b0;
      end

      // matching non-zero config groups; any break restarts count
      if (!sync_ok_i || !an_enable_i) begin
         next_st.match_cnt = 4'h0;
      end else if (cfg_valid_i) begin
         next_st.last_cfg = cfg_word_i;
         if (cfg_word_i == 16'h0000) begin
            next_st.match_cnt = 4'h0;
         end else if (cfg_word_i != st.last_cfg) begin
            next_st.match_cnt = 4'h1;
         end else if (st.match_cnt < MATCH_N) begin
            next_st.match_cnt = st.match_cnt + 4'h1;
         end
      end

      // partner an able needs all three conditions at once
      if (!sync_ok_i || !an_enable_i) begin
         next_st.lp_an_able = 1'b0;
      end else if (st.match_cnt >= MATCH_N) begin
         next_st.lp_an_able = 1'b1;
      end

      // software load of the next page to send
      if (wr_np) begin
         next_st.tx_np   = reg_wdata_i[`FAN_CW_NP];
         next_st.tx_mp   = reg_wdata_i[`FAN_CW_MP];
         next_st.tx_ack2 = reg_wdata_i[`FAN_CW_ACK2];
         next_st.tx_msg  = reg_wdata_i[`FAN_CW_MSG_HI:0];
      end

      // loaded indication; a fresh write beats consumption
      if (wr_np && is_1000x) begin
         next_st.np_loaded = 1'b1;
      end else if (np_consumed_i || !is_1000x) begin
         next_st.np_loaded = 1'b0;
      end

      // toggle flips on each received page, never by software
      if (rx_page_i.valid && link_up_i) begin
         next_st.tx_toggle = ~st.tx_toggle;
      end

      // partner next-page capture; base pages leave it alone
      if (!link_up_i) begin
         next_st.lp_np = `FAN_RST_WORD;
      end else if (next_pg && is_1000x) begin
         next_st.lp_np = rx_page_i.word;
      end

      // outgoing code word; silent outside 1000x
      next_st.tx_word = is_1000x ? np_val : 16'h0000;

      // read data stands one cycle after the strobe only
      next_st.rd_data = 16'h0000;
      if (reg_rd_i) begin
         case (reg_addr_i)
            `FAN_OFS_ABILITY:   next_st.rd_data = st.ability;
            `FAN_OFS_EXPANSION: next_st.rd_data = exp_val;
            `FAN_OFS_NP_TX:     next_st.rd_data = np_val;
            `FAN_OFS_LP_NP:     next_st.rd_data = st.lp_np;
            default:            next_st.rd_data = 16'h0000;
         endcase
      end

      // hardware and software reset share the same values
      if (sw_reset_i) begin
         next_st = '0;
         next_st.tx_mp  = `FAN_RST_MP;
         next_st.tx_msg = `FAN_RST_MSG;
      end
   end

   // state register; synchronous active-low reset
   always_ff @(posedge clk_i) begin
      if (!rstn_i) begin
         st        <= '0;
         st.tx_mp  <= `FAN_RST_MP;
         st.tx_msg <= `FAN_RST_MSG;
      end else begin
         st <= next_st;
      end
   end

   // outputs straight from flops
   assign reg_rdata_o  = st.rd_data;
   assign tx_word_o    = st.tx_word;
   assign np_loaded_o  = st.np_loaded;
   assign lp_an_able_o = st.lp_an_able;

   // checks on the block's own behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i || sw_reset_i);

   // a read of a given register
   sequence seq_rd(logic [4:0] ofs);
      reg_rd_i && reg_addr_i == ofs;
   endsequence

   // a next page arriving in 1000x
   sequence seq_next_page;
      next_pg && is_1000x;
   endsequence

   // a base page arriving with link up
   sequence seq_base_page;
      base_pg;
   endsequence

   a_sgmii_clear: assert property (
      !link_up_i |=> st.ability == 16'h0000)
      else $error("ability not cleared on link down");

   a_sgmii_load: assert property (
      seq_base_page and is_sgmii_med |=>
         st.ability == $past(rx_page_i.word))
      else $error("ability not loaded from base page");

   a_exp_reserved: assert property (
      seq_rd(`FAN_OFS_EXPANSION) |=> reg_rdata_o[15:4] == 12'h000)
      else $error("expansion reserved bits not zero");

   a_np_able_mode: assert property (
      seq_rd(`FAN_OFS_EXPANSION) and !is_1000x |=>
         !reg_rdata_o[`FAN_EXP_LP_NP_ABLE])
      else $error("partner next-page flag set outside 1000x");

   a_np_able_set: assert property (
      seq_base_page and is_1000x and rx_page_i.word[`FAN_CW_NP]
      |=> st.lp_np_able)
      else $error("partner next-page flag not set");

   a_np_able_clr: assert property (
      !link_up_i |=> !st.lp_np_able)
      else $error("partner next-page flag survived link down");

   a_local_np: assert property (
      seq_rd(`FAN_OFS_EXPANSION) |=>
         reg_rdata_o[`FAN_EXP_LOCAL_NP])
      else $error("local next-page bit not one");

   a_page_latch: assert property (
      rx_page_i.valid && link_up_i |=> st.page_rcvd)
      else $error("page received flag lost");

   a_page_rd_clr: assert property (
      seq_rd(`FAN_OFS_EXPANSION) and !rx_page_i.valid
      |=> !st.page_rcvd)
      else $error("page received flag not cleared by read");

   a_an_able_cond: assert property (
      $rose(st.lp_an_able) |->
         $past(sync_ok_i && an_enable_i && st.match_cnt >= MATCH_N))
      else $error("partner an able set without its conditions");

   a_np_loaded: assert property (
      wr_np && is_1000x |=> np_loaded_o)
      else $error("next page write did not mark loaded");

   a_tx_mode: assert property (
      !is_1000x |=> tx_word_o == 16'h0000 && !np_loaded_o)
      else $error("transmit register active outside 1000x");

   a_tx_bit14: assert property (
      ##1 !tx_word_o[`FAN_CW_ACK] && !np_val[`FAN_CW_ACK])
      else $error("transmit bit 14 not zero");

   a_tx_map: assert property (
      is_1000x |=> tx_word_o == $past(np_val))
      else $error("code word does not match register");

   a_toggle: assert property (
      rx_page_i.valid && link_up_i |=>
         st.tx_toggle != $past(st.tx_toggle))
      else $error("toggle did not invert on page");

   a_toggle_sw: assert property (
      wr_np && !rx_page_i.valid |=> $stable(st.tx_toggle))
      else $error("software changed the toggle");

   a_lp_np_load: assert property (
      seq_next_page |=> st.lp_np == $past(rx_page_i.word))
      else $error("next page not captured");

   a_lp_np_hold: assert property (
      seq_base_page |=> $stable(st.lp_np))
      else $error("base page altered the capture");

   a_lp_np_clr: assert property (
      !link_up_i |=> st.lp_np == 16'h0000)
      else $error("capture not cleared on link down");

   a_rst_vals: assert property (
      $rose(rstn_i) |-> st.tx_mp && st.tx_msg == `FAN_RST_MSG
                        && !st.tx_np && !st.tx_ack2)
      else $error("transmit register reset values wrong");

   a_ability_mode: assert property (
      seq_base_page and !is_sgmii_med |=> $stable(st.ability))
      else $error("ability loaded outside sgmii media");

   a_rd_ability: assert property (
      seq_rd(`FAN_OFS_ABILITY) |=> reg_rdata_o == $past(st.ability))
      else $error("ability read does not match stored word");

   a_lp_np_mode: assert property (
      next_pg && !is_1000x |=> $stable(st.lp_np))
      else $error("capture loaded outside 1000x");

   a_rd_lp_np: assert property (
      seq_rd(`FAN_OFS_LP_NP) |=> reg_rdata_o == $past(st.lp_np))
      else $error("capture read does not match stored word");

   a_np_consume: assert property (
      np_consumed_i && !wr_np |=> !np_loaded_o)
      else $error("loaded indication survived consumption");

endmodule

// *** fan_link_partner.sv ***
// link partner model: pages, config code groups, link and sync levels
// assumes the bench calls its tasks from right after a rising edge
`timescale 1ns/1ps

module fan_link_partner
   import fan_pkg::*;
(
   input  wire logic    clk_i,
   output fan_rx_page_t rx_page_o,
   output logic         cfg_valid_o,
   output logic [15:0]  cfg_word_o,
   output logic         link_up_o,
   output logic         sync_ok_o
);
   // idle buses carry the inverse of the last word, never a stale copy
   initial begin
      rx_page_o   = '0;
      cfg_valid_o = 1'b0;
      cfg_word_o  = 16'h0000;
      link_up_o   = 1'b1;
      sync_ok_o   = 1'b1;
   end

   // one page, valid for exactly one cycle
   task automatic send_page(input logic nxt, input logic [15:0] w);
      @(posedge clk_i);
      rx_page_o <= '{valid: 1'b1, is_next: nxt, word: w};
      @(posedge clk_i);
      rx_page_o <= '{valid: 1'b0, is_next: ~nxt, word: ~w};
   endtask

   // n back-to-back config code groups of one value
   task automatic send_cfg(input logic [15:0] w, input int n);
      repeat (n) begin
         @(posedge clk_i);
         cfg_valid_o <= 1'b1;
         cfg_word_o  <= w;
      end
      @(posedge clk_i);
      cfg_valid_o <= 1'b0;
      cfg_word_o  <= ~w;
   endtask

   // link lost for n cycles, then back
   task automatic link_drop(input int n);
      @(posedge clk_i);
      link_up_o <= 1'b0;
      repeat (n) @(posedge clk_i);
      link_up_o <= 1'b1;
   endtask

   // receive sync level
   task automatic set_sync(input logic v);
      @(posedge clk_i);
      sync_ok_o <= v;
   endtask
endmodule

// *** fan_page_xchg_tb.sv ***
// self-checking bench for the page-exchange registers
// assumes the link partner model and one 250 MHz clock
`timescale 1ns/1ps

module fan_page_xchg_tb;
   import fan_pkg::*;
   logic         clk_i, rstn_i, sw_reset_i, an_enable_i, np_consumed_i;
   logic [1:0]   mode_i;
   logic [4:0]   reg_addr_i;
   logic [15:0]  reg_wdata_i, reg_rdata_o, tx_word_o, cfg_word_i, exp_tx;
   logic         reg_wr_i, reg_rd_i, np_loaded_o, lp_an_able_o;
   logic         link_up_i, sync_ok_i, cfg_valid_i;
   fan_rx_page_t rx_page_i;
   int           bad_count, num_checks;

   // far side of the serial link
   fan_link_partner lp (.clk_i(clk_i), .rx_page_o(rx_page_i),
      .cfg_valid_o(cfg_valid_i), .cfg_word_o(cfg_word_i),
      .link_up_o(link_up_i), .sync_ok_o(sync_ok_i));

   fan_page_xchg u_dut (.clk_i(clk_i), .rstn_i(rstn_i),
      .sw_reset_i(sw_reset_i), .mode_i(mode_i), .an_enable_i(an_enable_i),
      .link_up_i(link_up_i), .sync_ok_i(sync_ok_i), .rx_page_i(rx_page_i),
      .cfg_valid_i(cfg_valid_i), .cfg_word_i(cfg_word_i),
      .np_consumed_i(np_consumed_i), .reg_addr_i(reg_addr_i),
      .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_rdata_o(reg_rdata_o), .tx_word_o(tx_word_o),
      .np_loaded_o(np_loaded_o), .lp_an_able_o(lp_an_able_o));

   // 4 ns clock
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end

   // settle past the edge before sampling
   task automatic idle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // compare tasks, one per result width
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR at %0t: got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk_reg({15'h0, got}, {15'h0, exp});
   endtask

   // one-cycle strobes; read data stand in the cycle after
   task automatic wr(input logic [4:0] a, input logic [15:0] w);
      @(posedge clk_i);
      reg_wr_i    <= 1'b1;
      reg_addr_i  <= a;
      reg_wdata_i <= w;
      @(posedge clk_i);
      reg_wr_i    <= 1'b0;
      #1;
   endtask

   task automatic rd(input logic [4:0] a, output logic [15:0] d);
      @(posedge clk_i);
      reg_rd_i   <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i   <= 1'b0;
      #1;
      d = reg_rdata_o;
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
      logic [15:0] d;
      rd(a, d);
      chk_reg(d, exp);
   endtask

   // one-cycle pulse on a control input
   task automatic pulse_consumed;
      @(posedge clk_i);
      np_consumed_i <= 1'b1;
      @(posedge clk_i);
      np_consumed_i <= 1'b0;
      #1;
   endtask

   // partner capability may take a few cycles to show
   task automatic wait_an(input logic e);
      #1;
      for (int i = 0; i < 4 && lp_an_able_o !== e; i++) idle(1);
      chk_bit(lp_an_able_o, e);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // hang guard, far above the fewer than 150 cycles the tests need
   initial begin
      repeat (5000) @(posedge clk_i);
      bad_count++;
      end_sim();
   end

   // main sequence
   initial begin
      logic [15:0] d;
      {rstn_i, sw_reset_i, an_enable_i, np_consumed_i} = 4'h0;
      {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = '0;
      mode_i = 2'h1;
      exp_tx = 16'h2001;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      idle(3);
      chk_reg(tx_word_o, 16'h2001);
      rd_chk(5'h07, 16'h2001);
      rd_chk(5'h06, 16'h0004);
      rd_chk(5'h08, 16'h0000);
      rd_chk(5'h1f, 16'h0000);
      $display("reset test done");
      // read-only bits 14 and 11 ignore the write
      wr(5'h07, 16'hffff);
      chk_bit(np_loaded_o, 1'b1);
      exp_tx = 16'hb7ff;
      idle(1);
      chk_reg(tx_word_o, exp_tx);
      rd_chk(5'h07, exp_tx);
      pulse_consumed();
      chk_bit(np_loaded_o, 1'b0);
      $display("transmit page test done");
      // base page with next-page bit set in every personality
      for (int m = 0; m < 4; m++) begin
         @(posedge clk_i);
         mode_i <= 2'(m);
         lp.link_drop(2);
         lp.send_page(1'b0, 16'h8001);
         exp_tx[11] = ~exp_tx[11];
         idle(2);
         rd_chk(5'h06, {12'h0, m == 1, 3'b110});
         rd_chk(5'h06, {12'h0, m == 1, 3'b100});
         rd_chk(5'h07, exp_tx);
         chk_reg(tx_word_o, (m == 1) ? exp_tx : 16'h0000);
         if (m == 3) begin
            rd_chk(5'h05, 16'h8001);
         end
      end
      wr(5'h07, 16'hffff);
      chk_bit(np_loaded_o, 1'b0);
      lp.link_drop(2);
      idle(1);
      rd_chk(5'h05, 16'h0000);
      lp.send_page(1'b1, 16'h1234);
      idle(2);
      rd_chk(5'h08, 16'h0000);
      $display("mode test done");
      // next page capture, base page left out, page beats a read
      @(posedge clk_i);
      mode_i <= 2'h1;
      lp.send_page(1'b1, 16'h5a5a);
      lp.send_page(1'b0, 16'h8000);
      idle(2);
      rd_chk(5'h08, 16'h5a5a);
      rd_chk(5'h06, 16'h000e);
      fork
         rd(5'h06, d);
         lp.send_page(1'b1, 16'h0f0f);
      join
      chk_reg(d, 16'h000c);
      idle(1);
      rd_chk(5'h06, 16'h000e);
      lp.link_drop(2);
      idle(2);
      rd_chk(5'h08, 16'h0000);
      rd_chk(5'h06, 16'h0004);
      $display("partner page test done");
      // three matching groups needed, with sync and enable
      @(posedge clk_i);
      an_enable_i <= 1'b1;
      lp.send_cfg(16'h4020, 2);
      lp.send_cfg(16'h4021, 1);
      wait_an(1'b0);
      lp.send_cfg(16'h4020, 3);
      wait_an(1'b1);
      rd_chk(5'h06, 16'h0005);
      lp.set_sync(1'b0);
      wait_an(1'b0);
      lp.set_sync(1'b1);
      an_enable_i <= 1'b0;
      lp.send_cfg(16'h4020, 3);
      wait_an(1'b0);
      $display("config group test done");
      // soft reset restores the transmit page
      @(posedge clk_i);
      sw_reset_i <= 1'b1;
      @(posedge clk_i);
      sw_reset_i <= 1'b0;
      idle(3);
      rd_chk(5'h07, 16'h2001);
      chk_reg(tx_word_o, 16'h2001);
      $display("soft reset test done");
      end_sim();
   end
endmodule
